// ==== design/trl_regs.sv ====
// Telemetry result and limit register bank with the voltage limit alerts.
// Assumes the serial port gives one-cycle read and write strobes with a
// sub-address, and that measurement and pin values arrive synchronous.
`timescale 1ns/1ps
`default_nettype none
module trl_regs
   import trl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic [6:0] addr_i,
   input wire logic [15:0] wr_data_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   // Comparator and status levels
   input wire logic supply_ovlo_i,
   input wire logic supply_above_battery_flag_i,
   input wire logic internal_rail_switching_ok_flag_i,
   input wire logic internal_rail_measure_ok_flag_i,
   input wire logic telemetry_ready_i,
   // Measurement results
   input wire logic [15:0] battery_voltage_i,
   input wire logic [15:0] supply_voltage_i,
   input wire logic [15:0] system_rail_i,
   input wire logic [15:0] battery_current_i,
   input wire logic [15:0] supply_current_i,
   input wire logic [15:0] junction_temperature_i,
   input wire logic [15:0] thermistor_divider_i,
   input wire logic [15:0] series_resistance_i,
   input wire logic [15:0] battery_voltage_filtered_i,
   input wire logic [15:0] resistance_calc_current_snapshot_i,
   input wire logic [2:0] thermistor_temp_zone_i,
   input wire logic temp_zone_charging_enable_i,
   input wire logic [3:0] battery_kind_pins_i,
   input wire logic [3:0] series_count_pins_i,
   input wire logic kind_programmable_i,
   input wire logic [4:0] charge_current_dac_code_i,
   input wire logic [5:0] charge_voltage_dac_code_i,
   input wire logic [5:0] supply_current_limit_dac_code_i,
   // Alert outputs
   output logic [15:0] limit_enable_o,
   output logic smbalert_req_o
);
   logic [15:0] bat_lo_ff;
   logic [15:0] bat_hi_ff;
   logic [15:0] sup_lo_ff;
   logic [15:0] sup_hi_ff;
   logic [15:0] en_ff;
   logic [3:0] alert_ff;
   logic [3:0] nxt_alert;
   logic [15:0] nxt_rd;
   logic [15:0] reg_rd_ff;
   logic rd_pend_ff;
   logic mem_sel_ff;
   logic [15:0] mem_rd;
   logic rd_valid_ff;
   logic [15:0] rd_data_ff;
   logic smbalert_ff;

   // Signed less-than used by every limit excursion and the low-limit checks
   function automatic logic below(input logic [15:0] a, input logic [15:0] b);
      below = $signed(a) < $signed(b);
   endfunction

   // Address decode
   wire wr_bat_lo = wr_stb_i && (addr_i == ADR_BAT_LO);
   wire wr_bat_hi = wr_stb_i && (addr_i == ADR_BAT_HI);
   wire wr_sup_lo = wr_stb_i && (addr_i == ADR_SUP_LO);
   wire wr_sup_hi = wr_stb_i && (addr_i == ADR_SUP_HI);
   wire wr_en = wr_stb_i && (addr_i == ADR_LIMIT_EN);
   wire wr_alert = wr_stb_i && (addr_i == ADR_LIMIT_ALERTS);
   wire in_chg = (addr_i >= ADR_CHG_SET_FIRST) && (addr_i <= ADR_CHG_SET_LAST);
   wire chg_wr = wr_stb_i && in_chg && kind_programmable_i;
   wire [4:0] chg_idx = 5'(addr_i - ADR_CHG_SET_FIRST);

   // Limit excursions, signed so negative readings sit below any positive limit
   wire [3:0] excursion = {below(battery_voltage_i, bat_lo_ff),
                           below(bat_hi_ff, battery_voltage_i),
                           below(supply_voltage_i, sup_lo_ff),
                           below(sup_hi_ff, supply_voltage_i)};
   wire [3:0] en_bits = {en_ff[BIT_EN_BAT_LO], en_ff[BIT_EN_BAT_HI],
                         en_ff[BIT_EN_SUP_LO], en_ff[BIT_EN_SUP_HI]};
   // Alert map bits match their enable positions in the alert register
   wire [3:0] wr_alert_bits = {wr_data_i[BIT_EN_BAT_LO], wr_data_i[BIT_EN_BAT_HI],
                               wr_data_i[BIT_EN_SUP_LO], wr_data_i[BIT_EN_SUP_HI]};
   wire [3:0] keep_mask = wr_alert ? wr_alert_bits : 4'hF;

   // Set wins over a clear in the same cycle; disable drops the bit
   assign nxt_alert = ((alert_ff & keep_mask) | excursion) & en_bits;

   wire [15:0] status_word = {12'h000, supply_ovlo_i,
                              supply_above_battery_flag_i,
                              internal_rail_switching_ok_flag_i,
                              internal_rail_measure_ok_flag_i};
   wire [15:0] alert_word = {4'h0, alert_ff, 8'h00};
   wire [2:0] zone_bits = temp_zone_charging_enable_i ? thermistor_temp_zone_i : 3'h0;

   // Read multiplexer for everything outside the setting memory
   always_comb begin
      nxt_rd = RST_ZERO;
      unique case (addr_i)
         ADR_BAT_LO: nxt_rd = bat_lo_ff;
         ADR_BAT_HI: nxt_rd = bat_hi_ff;
         ADR_SUP_LO: nxt_rd = sup_lo_ff;
         ADR_SUP_HI: nxt_rd = sup_hi_ff;
         ADR_LIMIT_EN: nxt_rd = en_ff;
         ADR_LIMIT_ALERTS: nxt_rd = alert_word;
         ADR_SYS_STATUS: nxt_rd = status_word;
         ADR_BAT_V: nxt_rd = battery_voltage_i;
         ADR_SUP_V: nxt_rd = supply_voltage_i;
         ADR_SYS_V: nxt_rd = system_rail_i;
         ADR_BAT_I: nxt_rd = battery_current_i;
         ADR_SUP_I: nxt_rd = supply_current_i;
         ADR_DIE_T: nxt_rd = junction_temperature_i;
         ADR_NTC: nxt_rd = thermistor_divider_i;
         ADR_BSR: nxt_rd = series_resistance_i;
         ADR_ZONE: nxt_rd = {13'h0000, zone_bits};
         ADR_KIND: nxt_rd = {4'h0, battery_kind_pins_i, 4'h0, series_count_pins_i};
         ADR_ICHG_DAC: nxt_rd = {11'h000, charge_current_dac_code_i};
         ADR_VCHG_DAC: nxt_rd = {10'h000, charge_voltage_dac_code_i};
         ADR_ILIM_DAC: nxt_rd = {10'h000, supply_current_limit_dac_code_i};
         ADR_BAT_FILT: nxt_rd = battery_voltage_filtered_i;
         ADR_BSR_I: nxt_rd = resistance_calc_current_snapshot_i;
         ADR_RSVD: nxt_rd = RST_ZERO;
         ADR_READY: nxt_rd = {15'h0000, telemetry_ready_i};
         default: nxt_rd = RST_ZERO;
      endcase
   end

   trl_setting_mem u_mem (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(chg_wr),
      .addr_i(chg_idx),
      .wr_data_i(wr_data_i),
      .rd_data_o(mem_rd)
   );

   // Limit words; no write path reaches the reserved slot
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bat_lo_ff <= RST_LOW_LIMIT;
         bat_hi_ff <= RST_HIGH_LIMIT;
         sup_lo_ff <= RST_LOW_LIMIT;
         sup_hi_ff <= RST_HIGH_LIMIT;
         en_ff <= RST_ZERO;
      end else begin
         if (wr_bat_lo) bat_lo_ff <= wr_data_i;
         if (wr_bat_hi) bat_hi_ff <= wr_data_i;
         if (wr_sup_lo) sup_lo_ff <= wr_data_i;
         if (wr_sup_hi) sup_hi_ff <= wr_data_i;
         if (wr_en) en_ff <= wr_data_i;
      end
   end

   // Sticky alerts and the alert request
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alert_ff <= 4'h0;
         smbalert_ff <= 1'b0;
      end else begin
         alert_ff <= nxt_alert;
         smbalert_ff <= |nxt_alert;
      end
   end

   // Read pipeline: stage one samples, stage two presents, matching memory latency
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rd_ff <= RST_ZERO;
         rd_pend_ff <= 1'b0;
         mem_sel_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= RST_ZERO;
      end else begin
         reg_rd_ff <= nxt_rd;
         rd_pend_ff <= rd_stb_i;
         mem_sel_ff <= in_chg;
         rd_valid_ff <= rd_pend_ff;
         if (rd_pend_ff) rd_data_ff <= mem_sel_ff ? mem_rd : reg_rd_ff;
      end
   end

   assign rd_data_o = rd_data_ff;
   assign rd_valid_o = rd_valid_ff;
   assign limit_enable_o = en_ff;
   assign smbalert_req_o = smbalert_ff;

   // Checks
   property p_bat_lo;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (en_ff[BIT_EN_BAT_LO] && below(battery_voltage_i, bat_lo_ff)) |=> alert_ff[3];
   endproperty
   a_bat_lo: assert property (p_bat_lo) else $error("battery low alert missed");

   property p_sup_lo;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (en_ff[BIT_EN_SUP_LO] && below(supply_voltage_i, sup_lo_ff)) |=> alert_ff[1];
   endproperty
   a_sup_lo: assert property (p_sup_lo) else $error("supply low alert missed");

   property p_sticky;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (alert_ff[3] && !wr_alert && en_ff[BIT_EN_BAT_LO] && !wr_en) |=> alert_ff[3];
   endproperty
   a_sticky: assert property (p_sticky) else $error("alert dropped alone");

   property p_disable;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !en_ff[BIT_EN_BAT_LO] |=> !alert_ff[3];
   endproperty
   a_disable: assert property (p_disable) else $error("alert without enable");

   property p_alert_out;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (|alert_ff) |-> smbalert_req_o;
   endproperty
   a_alert_out: assert property (p_alert_out) else $error("alert output low");

   property p_chg_ro;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_stb_i && in_chg && !kind_programmable_i) |-> !chg_wr;
   endproperty
   a_chg_ro: assert property (p_chg_ro) else $error("fixed kind write taken");

   property p_rd_lat;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_stb_i |-> ##2 rd_valid_o;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

   property p_rsvd;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_RSVD) |-> ##2 (rd_data_o == RST_ZERO);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");

   property p_ready;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_READY) |-> ##2 (rd_data_o[0] == $past(telemetry_ready_i, 2));
   endproperty
   a_ready: assert property (p_ready) else $error("ready bit wrong");

   // Status bits and limit writes held against the pins and write data; spare read bits held at zero; high-limit alerts
   property p_ovlo;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_SYS_STATUS) |->
         ##2 (rd_data_o[BIT_OVLO] == $past(supply_ovlo_i, 2));
   endproperty
   a_ovlo: assert property (p_ovlo) else $error("overvoltage status bit wrong");

   property p_sup_gt_bat;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_SYS_STATUS) |->
         ##2 (rd_data_o[BIT_SUP_GT_BAT] == $past(supply_above_battery_flag_i, 2));
   endproperty
   a_sup_gt_bat: assert property (p_sup_gt_bat) else $error("supply margin bit wrong");

   property p_rail_sw;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_SYS_STATUS) |->
         ##2 (rd_data_o[BIT_RAIL_SW] == $past(internal_rail_switching_ok_flag_i, 2));
   endproperty
   a_rail_sw: assert property (p_rail_sw) else $error("switching rail bit wrong");

   property p_rail_meas;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_SYS_STATUS) |->
         ##2 (rd_data_o[BIT_RAIL_MEAS] == $past(internal_rail_measure_ok_flag_i, 2));
   endproperty
   a_rail_meas: assert property (p_rail_meas) else $error("measure rail bit wrong");

   property p_kind;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_KIND) |->
         ##2 (rd_data_o[15:12] == 4'h0 && rd_data_o[7:4] == 4'h0);
   endproperty
   a_kind: assert property (p_kind) else $error("pin readback spare bits set");

   property p_zone_off;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_ZONE && !temp_zone_charging_enable_i) |->
         ##2 (rd_data_o == RST_ZERO);
   endproperty
   a_zone_off: assert property (p_zone_off) else $error("zone shown while disabled");

   property p_dac_width;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_stb_i && addr_i == ADR_ICHG_DAC) |-> ##2 (rd_data_o[15:5] == 11'h000);
   endproperty
   a_dac_width: assert property (p_dac_width) else $error("current code too wide");

   property p_bat_lo_wr;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_stb_i && addr_i == ADR_BAT_LO) |=> (bat_lo_ff == $past(wr_data_i));
   endproperty
   a_bat_lo_wr: assert property (p_bat_lo_wr) else $error("battery low limit lost");

   property p_sup_hi_wr;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_stb_i && addr_i == ADR_SUP_HI) |=> (sup_hi_ff == $past(wr_data_i));
   endproperty
   a_sup_hi_wr: assert property (p_sup_hi_wr) else $error("supply high limit lost");

   property p_en_out;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_stb_i && addr_i == ADR_LIMIT_EN) |=> (limit_enable_o == $past(wr_data_i));
   endproperty
   a_en_out: assert property (p_en_out) else $error("enable word not shown");

   property p_bat_hi;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (en_ff[BIT_EN_BAT_HI] && ($signed(battery_voltage_i) > $signed(bat_hi_ff))) |=>
         alert_ff[2];
   endproperty
   a_bat_hi: assert property (p_bat_hi) else $error("battery high alert missed");

   property p_sup_hi;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (en_ff[BIT_EN_SUP_HI] && ($signed(supply_voltage_i) > $signed(sup_hi_ff))) |=>
         alert_ff[0];
   endproperty
   a_sup_hi: assert property (p_sup_hi) else $error("supply high alert missed");

   c_bat_alert: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(alert_ff[3]));
   c_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) wr_alert && |alert_ff);
   c_chg_wr: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) chg_wr);
   c_sup_alert: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(alert_ff[1]));
   c_hi_alerts: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      alert_ff[2] && alert_ff[0]);
endmodule
`default_nettype wire

// ==== design/trl_pkg.sv ====
// Package for the telemetry result and limit register bank.
// Assumes one core clock; all register indices are 7-bit sub-addresses.
package trl_pkg;
   localparam logic [6:0] ADR_BAT_LO = 7'h01;
   localparam logic [6:0] ADR_BAT_HI = 7'h02;
   localparam logic [6:0] ADR_SUP_LO = 7'h03;
   localparam logic [6:0] ADR_SUP_HI = 7'h04;
   localparam logic [6:0] ADR_LIMIT_EN = 7'h0D;
   localparam logic [6:0] ADR_CHG_SET_FIRST = 7'h1A;
   localparam logic [6:0] ADR_CHG_SET_LAST = 7'h2D;
   localparam logic [6:0] ADR_LIMIT_ALERTS = 7'h36;
   localparam logic [6:0] ADR_SYS_STATUS = 7'h39;
   localparam logic [6:0] ADR_BAT_V = 7'h3A;
   localparam logic [6:0] ADR_SUP_V = 7'h3B;
   localparam logic [6:0] ADR_SYS_V = 7'h3C;
   localparam logic [6:0] ADR_BAT_I = 7'h3D;
   localparam logic [6:0] ADR_SUP_I = 7'h3E;
   localparam logic [6:0] ADR_DIE_T = 7'h3F;
   localparam logic [6:0] ADR_NTC = 7'h40;
   localparam logic [6:0] ADR_BSR = 7'h41;
   localparam logic [6:0] ADR_ZONE = 7'h42;
   localparam logic [6:0] ADR_KIND = 7'h43;
   localparam logic [6:0] ADR_ICHG_DAC = 7'h44;
   localparam logic [6:0] ADR_VCHG_DAC = 7'h45;
   localparam logic [6:0] ADR_ILIM_DAC = 7'h46;
   localparam logic [6:0] ADR_BAT_FILT = 7'h47;
   localparam logic [6:0] ADR_BSR_I = 7'h48;
   localparam logic [6:0] ADR_RSVD = 7'h49;
   localparam logic [6:0] ADR_READY = 7'h4A;
   // Status, enable and pin readback bit positions
   localparam int BIT_OVLO = 3;
   localparam int BIT_SUP_GT_BAT = 2;
   localparam int BIT_RAIL_SW = 1;
   localparam int BIT_RAIL_MEAS = 0;
   localparam int BIT_EN_BAT_LO = 11;
   localparam int BIT_EN_BAT_HI = 10;
   localparam int BIT_EN_SUP_LO = 9;
   localparam int BIT_EN_SUP_HI = 8;
   localparam int KIND_LSB = 8;
   localparam int COUNT_LSB = 0;
   // Reset values
   localparam logic [15:0] RST_LOW_LIMIT = 16'h8000;
   localparam logic [15:0] RST_HIGH_LIMIT = 16'h7FFF;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // Number of charger setting words held locally
   localparam int CHG_WORDS = 20;
endpackage

// ==== design/trl_setting_mem.sv ====
// Small memory for the charger setting words, registered read data.
// Assumes the caller decodes address range and write permission.
`timescale 1ns/1ps
`default_nettype none
module trl_setting_mem
   import trl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wr_data_i,
   output logic [15:0] rd_data_o
);
   logic [15:0] mem_ff [CHG_WORDS];

   // Storage; reset keeps a defined value for every word
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < CHG_WORDS; i++) begin
            mem_ff[i] <= RST_ZERO;
         end
      end else if (wr_en_i) begin
         mem_ff[addr_i] <= wr_data_i;
      end
   end

   // Registered read, one cycle after the address
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= RST_ZERO;
      end else begin
         rd_data_o <= (32'(addr_i) < CHG_WORDS) ? mem_ff[addr_i] : RST_ZERO;
      end
   end
endmodule
`default_nettype wire

// ==== dv/trl_host_model.sv ====
// Host side of the register port: one-cycle strobes and a bounded wait for the read answer.
// Assumes the bank takes strobes at the rising edge and answers a read two edges later.
`timescale 1ns/1ps
`default_nettype none
module trl_host_model (
   input wire logic ref_clk_i,
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i,
   output logic wr_stb_o,
   output logic rd_stb_o,
   output logic [6:0] addr_o,
   output logic [15:0] wr_data_o
);
   // Idle bus at time zero
   initial begin
      wr_stb_o = 1'b0;
      rd_stb_o = 1'b0;
      addr_o = 7'h00;
      wr_data_o = 16'h0000;
   end

   // Write: request after a falling edge, held over exactly one rising edge
   task automatic put(input logic [6:0] a, input logic [15:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      wr_data_o = d;
      wr_stb_o = 1'b1;
      @(negedge ref_clk_i);
      wr_stb_o = 1'b0;
      // Released lines carry the inverse so stale values never look valid
      addr_o = ~a;
      wr_data_o = ~d;
   endtask

   // Read: one strobe, then the answer is taken at the edge that shows it
   task automatic get(input logic [6:0] a, output logic [15:0] d, output logic ok);
      int n;
      ok = 1'b0;
      d = 16'h0000;
      @(negedge ref_clk_i);
      addr_o = a;
      rd_stb_o = 1'b1;
      @(negedge ref_clk_i);
      rd_stb_o = 1'b0;
      addr_o = ~a;
      for (n = 0; n < 4 && ok == 1'b0; n++) begin
         @(posedge ref_clk_i);
         #1;
         if (rd_valid_i === 1'b1) begin
            d = rd_data_i;
            ok = 1'b1;
         end
      end
      // Return on a falling edge so the caller's next stimulus lands off the sampling edge
      @(negedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// ==== dv/telemetry_result_and_limit_regs_bench.sv ====
// Self-checking bench for the telemetry result and limit register bank.
// Assumes the host model drives the register port; all other inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
module telemetry_result_and_limit_regs_bench
   import trl_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wr_stb, rd_stb, rd_valid, smbalert;
   logic ready = 1'b0, zone_en = 1'b0, prog = 1'b0;
   logic [6:0] addr;
   logic [15:0] wr_data, rd_data, lim_en;
   logic [3:0] st = 4'h0, kind = 4'h0, cnt = 4'h0;
   logic [2:0] zone = 3'h0;
   logic [4:0] idac = 5'h00;
   logic [5:0] vdac = 6'h00, ldac = 6'h00;
   logic [15:0] res [10];
   logic [6:0] res_adr [10] = '{ADR_BAT_V, ADR_SUP_V, ADR_SYS_V, ADR_BAT_I, ADR_SUP_I,
      ADR_DIE_T, ADR_NTC, ADR_BSR, ADR_BAT_FILT, ADR_BSR_I};
   int n_errors = 0;
   int num_checks = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   trl_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb),
      .rd_stb_i(rd_stb), .addr_i(addr), .wr_data_i(wr_data), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .supply_ovlo_i(st[3]), .supply_above_battery_flag_i(st[2]),
      .internal_rail_switching_ok_flag_i(st[1]), .internal_rail_measure_ok_flag_i(st[0]),
      .telemetry_ready_i(ready), .battery_voltage_i(res[0]), .supply_voltage_i(res[1]),
      .system_rail_i(res[2]), .battery_current_i(res[3]), .supply_current_i(res[4]),
      .junction_temperature_i(res[5]), .thermistor_divider_i(res[6]),
      .series_resistance_i(res[7]), .battery_voltage_filtered_i(res[8]),
      .resistance_calc_current_snapshot_i(res[9]), .thermistor_temp_zone_i(zone),
      .temp_zone_charging_enable_i(zone_en), .battery_kind_pins_i(kind),
      .series_count_pins_i(cnt), .kind_programmable_i(prog),
      .charge_current_dac_code_i(idac), .charge_voltage_dac_code_i(vdac),
      .supply_current_limit_dac_code_i(ldac), .limit_enable_o(lim_en),
      .smbalert_req_o(smbalert));

   trl_host_model host (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .addr_o(addr), .wr_data_o(wr_data));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A missing answer shows up as a failed check of the valid flag
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      host.get(a, d, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(d, exp);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      n_errors++;
      wrap_up();
   end

   initial begin
      for (int i = 0; i < 10; i++) res[i] = 16'h8421 + 16'(i) * 16'h1357;
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      // Reset contents of limits, enables and alerts
      rd(ADR_BAT_LO, RST_LOW_LIMIT);
      rd(ADR_BAT_HI, RST_HIGH_LIMIT);
      rd(ADR_SUP_LO, RST_LOW_LIMIT);
      rd(ADR_SUP_HI, RST_HIGH_LIMIT);
      rd(ADR_LIMIT_EN, RST_ZERO);
      rd(ADR_LIMIT_ALERTS, RST_ZERO);
      // Every result word at its own address, all values distinct
      for (int i = 0; i < 10; i++) begin
         rd(res_adr[i], res[i]);
      end
      // Status levels, two complementary patterns
      for (int p = 0; p < 2; p++) begin
         @(negedge ref_clk_i);
         st = (p == 0) ? 4'hA : 4'h5;
         rd(ADR_SYS_STATUS, {12'h000, st});
      end
      // Zone field reads zero until zone charging is enabled
      zone = 3'h5;
      rd(ADR_ZONE, 16'h0000);
      zone_en = 1'b1;
      rd(ADR_ZONE, 16'h0005);
      kind = 4'hC;
      cnt = 4'h3;
      idac = 5'h15;
      vdac = 6'h2A;
      ldac = 6'h3F;
      rd(ADR_KIND, 16'h0C03);
      rd(ADR_ICHG_DAC, 16'h0015);
      rd(ADR_VCHG_DAC, 16'h002A);
      rd(ADR_ILIM_DAC, 16'h003F);
      host.put(ADR_ICHG_DAC, 16'hFFFF);
      rd(ADR_ICHG_DAC, 16'h0015);
      rd(ADR_READY, 16'h0000);
      ready = 1'b1;
      rd(ADR_READY, 16'h0001);
      // Setting span only writable with a programmable kind
      host.put(ADR_CHG_SET_FIRST, 16'h1234);
      rd(ADR_CHG_SET_FIRST, 16'h0000);
      prog = 1'b1;
      host.put(ADR_CHG_SET_FIRST, 16'h1234);
      host.put(ADR_CHG_SET_LAST, 16'hBEEF);
      rd(ADR_CHG_SET_FIRST, 16'h1234);
      rd(ADR_CHG_SET_LAST, 16'hBEEF);
      rd(7'h2E, 16'h0000);
      host.put(ADR_RSVD, 16'hFFFF);
      rd(ADR_RSVD, 16'h0000);
      host.put(ADR_BAT_HI, 16'h7F00);
      host.put(ADR_SUP_HI, 16'h1357);
      rd(ADR_BAT_HI, 16'h7F00);
      rd(ADR_SUP_HI, 16'h1357);
      // Battery low: -1 is below zero only when compared signed
      res[0] = 16'hFFFF;
      host.put(ADR_BAT_LO, 16'h0000);
      host.put(ADR_LIMIT_EN, 16'h0800);
      repeat (3) @(negedge ref_clk_i);
      chk({15'h0000, smbalert}, 16'h0001);
      chk(lim_en, 16'h0800);
      rd(ADR_LIMIT_ALERTS, 16'h0800);
      res[0] = 16'h0100;
      host.put(ADR_LIMIT_ALERTS, 16'h0800);
      rd(ADR_LIMIT_ALERTS, 16'h0800);
      host.put(ADR_LIMIT_ALERTS, 16'h0000);
      rd(ADR_LIMIT_ALERTS, 16'h0000);
      chk({15'h0000, smbalert}, 16'h0000);
      // Supply low, then cleared by removing the enable
      res[1] = 16'h8000;
      host.put(ADR_SUP_LO, 16'hFF00);
      host.put(ADR_LIMIT_EN, 16'h0200);
      repeat (3) @(negedge ref_clk_i);
      chk({15'h0000, smbalert}, 16'h0001);
      rd(ADR_LIMIT_ALERTS, 16'h0200);
      rd(ADR_SUP_LO, 16'hFF00);
      host.put(ADR_LIMIT_EN, 16'h0000);
      rd(ADR_LIMIT_ALERTS, 16'h0000);
      chk({15'h0000, smbalert}, 16'h0000);
      // High limits: both results one count above their upper words
      res[0] = 16'h7F01;
      res[1] = 16'h1358;
      host.put(ADR_LIMIT_EN, 16'h0500);
      repeat (3) @(negedge ref_clk_i);
      chk({15'h0000, smbalert}, 16'h0001);
      chk(lim_en, 16'h0500);
      rd(ADR_LIMIT_ALERTS, 16'h0500);
      // Reset in mid-run drops the alerts and restores the limit words
      rst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      chk({15'h0000, smbalert}, 16'h0000);
      rd(ADR_BAT_HI, RST_HIGH_LIMIT);
      rd(ADR_LIMIT_ALERTS, RST_ZERO);
      wrap_up();
   end
endmodule
`default_nettype wire
